// ### shared/sssa_pkg.sv
/*
 * Shared constants and types for the shift, shuffle and select ALU slice.
 * Assumes one core clock and a synchronous active-high reset.
 */
package sssa_pkg;
  localparam int unsigned SSSA_W       = 32;
  localparam int unsigned SSSA_CW      = 4;
  localparam int unsigned SSSA_AMT_W   = 8;
  localparam int unsigned SSSA_MAX_SH  = 31;
  localparam int unsigned SSSA_BYTE_W  = 8;
  localparam int unsigned SSSA_HALF_W  = 16;
  localparam int unsigned SSSA_NBYTES  = 4;
  localparam logic [31:0] SSSA_RES_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    SSSA_OP_SHRU,
    SSSA_OP_SHUF_BH,
    SSSA_OP_SHUF_BL,
    SSSA_OP_SHUF_HH,
    SSSA_OP_SHUF_HL,
    SSSA_OP_EVEN,
    SSSA_OP_ODD,
    SSSA_OP_SEL_T,
    SSSA_OP_SEL_PB,
    SSSA_OP_SEL_F
  } sssa_op_e;
endpackage

// ### shared/sssa_ops_if.sv
/*
 * Operand and result carrier between the slice top and its datapath units.
 * Assumes all signals are combinational within one cycle.
 */
`timescale 1ns/100ps
interface sssa_ops_if;
  import sssa_pkg::*;
  sssa_op_e          op;
  logic [SSSA_W-1:0] src1;
  logic [SSSA_W-1:0] opd2;
  logic [SSSA_CW-1:0] cond;
  logic [SSSA_W-1:0] shuf_res;
  logic [SSSA_W-1:0] sel_res;
  modport top (output op, output src1, output opd2, output cond,
               input shuf_res, input sel_res);
  modport shuf (input op, input src1, input opd2, output shuf_res);
  modport sel (input op, input src1, input opd2, input cond, output sel_res);
endinterface

// ### core/sssa_shuffle.sv
/*
 * Combinational shift and shuffle unit.
 * Assumes operands are stable within the cycle that the top registers.
 */
`timescale 1ns/100ps
module sssa_shuffle (
  sssa_ops_if.shuf bus
);
  import sssa_pkg::*;
  logic [SSSA_BYTE_W-1:0] a [SSSA_NBYTES];
  logic [SSSA_BYTE_W-1:0] b [SSSA_NBYTES];
  logic [SSSA_AMT_W-1:0]  amt;

  for (genvar g = 0; g < SSSA_NBYTES; g++) begin : g_split
    assign a[g] = bus.src1[g*SSSA_BYTE_W +: SSSA_BYTE_W];
    assign b[g] = bus.opd2[g*SSSA_BYTE_W +: SSSA_BYTE_W];
  end
  assign amt = bus.opd2[SSSA_AMT_W-1:0];

  always_comb begin
    unique case (bus.op)
      SSSA_OP_SHRU: begin
        if (amt > SSSA_AMT_W'(SSSA_MAX_SH)) begin
          bus.shuf_res = '0;
        end else begin
          bus.shuf_res = bus.src1 >> amt;
        end
      end
      SSSA_OP_SHUF_BH: bus.shuf_res = {b[3], a[3], b[2], a[2]};
      SSSA_OP_SHUF_BL: bus.shuf_res = {b[1], a[1], b[0], a[0]};
      SSSA_OP_SHUF_HH: bus.shuf_res = {bus.opd2[SSSA_W-1 -: SSSA_HALF_W],
                                       bus.src1[SSSA_W-1 -: SSSA_HALF_W]};
      SSSA_OP_SHUF_HL: bus.shuf_res = {bus.opd2[SSSA_HALF_W-1:0],
                                       bus.src1[SSSA_HALF_W-1:0]};
      SSSA_OP_EVEN:    bus.shuf_res = {b[2], a[2], b[0], a[0]};
      SSSA_OP_ODD:     bus.shuf_res = {b[3], a[3], b[1], a[1]};
      default:         bus.shuf_res = '0;
    endcase
  end
endmodule

// ### core/sssa_select.sv
/*
 * Combinational word and per-byte select unit.
 * Assumes the issue logic has already sign- or zero-extended the immediate.
 */
`timescale 1ns/100ps
module sssa_select (
  sssa_ops_if.sel bus
);
  import sssa_pkg::*;
  logic [SSSA_W-1:0] per_byte;

  for (genvar g = 0; g < SSSA_NBYTES; g++) begin : g_byte
    assign per_byte[g*SSSA_BYTE_W +: SSSA_BYTE_W] = bus.cond[g] ?
        bus.src1[g*SSSA_BYTE_W +: SSSA_BYTE_W] :
        bus.opd2[g*SSSA_BYTE_W +: SSSA_BYTE_W];
  end

  always_comb begin
    unique case (bus.op)
      SSSA_OP_SEL_T:  bus.sel_res = (bus.cond == '0) ? bus.opd2 : bus.src1;
      SSSA_OP_SEL_PB: bus.sel_res = per_byte;
      SSSA_OP_SEL_F:  bus.sel_res = (bus.cond == '0) ? bus.src1 : bus.opd2;
      default:        bus.sel_res = '0;
    endcase
  end
endmodule

// ### core/sssa_alu.sv
/*
 * Shift, shuffle and select ALU slice with one registered result stage.
 * Assumes the issue logic presents operands and a valid strobe in one cycle
 * and takes the result one cycle later; the immediate arrives pre-extended.
 */
`timescale 1ns/100ps
module sssa_alu (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      issue_valid_i,
  input  wire sssa_pkg::sssa_op_e        issue_op_i,
  input  wire logic [sssa_pkg::SSSA_W-1:0]  src1_i,
  input  wire logic [sssa_pkg::SSSA_W-1:0]  opd2_i,
  input  wire logic [sssa_pkg::SSSA_CW-1:0] select_condition_register_i,
  output logic                           result_valid_o,
  output logic [sssa_pkg::SSSA_W-1:0]    result_o
);
  import sssa_pkg::*;

  sssa_ops_if ops ();
  logic              valid_d;
  logic              valid_q;
  logic [SSSA_W-1:0] res_d;
  logic [SSSA_W-1:0] res_q;
  logic              is_sel;

  assign ops.op   = issue_op_i;
  assign ops.src1 = src1_i;
  assign ops.opd2 = opd2_i;
  assign ops.cond = select_condition_register_i;

  sssa_shuffle u_shuffle (
    .bus (ops.shuf)
  );

  sssa_select u_select (
    .bus (ops.sel)
  );

  assign is_sel = (issue_op_i == SSSA_OP_SEL_T) || (issue_op_i == SSSA_OP_SEL_PB) ||
                  (issue_op_i == SSSA_OP_SEL_F);

  // Any opcode is taken on any cycle; no stall or fault path exists.
  always_comb begin
    valid_d = issue_valid_i;
    res_d   = res_q;
    if (issue_valid_i) begin
      res_d = is_sel ? ops.sel_res : ops.shuf_res;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      res_q   <= SSSA_RES_RST;
    end else begin
      valid_q <= valid_d;
      res_q   <= res_d;
    end
  end

  assign result_valid_o = valid_q;
  assign result_o       = res_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  shr_zero_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SHRU && opd2_i[7:0] > 8'd31
    |=> result_o == 32'h0000_0000)
    else $error("shift above 31 not zero");
  shr_value_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SHRU && opd2_i[7:0] <= 8'd31
    |=> result_o == ($past(src1_i) >> $past(opd2_i[4:0])))
    else $error("logical shift wrong");
  byte_high_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SHUF_BH
    |=> result_o == {$past(opd2_i[31:24]), $past(src1_i[31:24]),
                     $past(opd2_i[23:16]), $past(src1_i[23:16])})
    else $error("byte high shuffle wrong");
  byte_low_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SHUF_BL
    |=> result_o == {$past(opd2_i[15:8]), $past(src1_i[15:8]),
                     $past(opd2_i[7:0]), $past(src1_i[7:0])})
    else $error("byte low shuffle wrong");
  half_high_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SHUF_HH
    |=> result_o == {$past(opd2_i[31:16]), $past(src1_i[31:16])})
    else $error("half high shuffle wrong");
  half_low_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SHUF_HL
    |=> result_o == {$past(opd2_i[15:0]), $past(src1_i[15:0])})
    else $error("half low shuffle wrong");
  even_lane_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_EVEN
    |=> result_o == {$past(opd2_i[23:16]), $past(src1_i[23:16]),
                     $past(opd2_i[7:0]), $past(src1_i[7:0])})
    else $error("even lane shuffle wrong");
  odd_lane_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_ODD
    |=> result_o == {$past(opd2_i[31:24]), $past(src1_i[31:24]),
                     $past(opd2_i[15:8]), $past(src1_i[15:8])})
    else $error("odd lane shuffle wrong");
  sel_true_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SEL_T
    |=> result_o == ($past(select_condition_register_i) == 4'h0 ?
                     $past(opd2_i) : $past(src1_i)))
    else $error("true select wrong");
  sel_byte_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SEL_PB
    |=> result_o == {($past(select_condition_register_i[3]) ? $past(src1_i[31:24]) :
                                                               $past(opd2_i[31:24])),
                     ($past(select_condition_register_i[2]) ? $past(src1_i[23:16]) :
                                                               $past(opd2_i[23:16])),
                     ($past(select_condition_register_i[1]) ? $past(src1_i[15:8]) :
                                                               $past(opd2_i[15:8])),
                     ($past(select_condition_register_i[0]) ? $past(src1_i[7:0]) :
                                                               $past(opd2_i[7:0]))})
    else $error("byte select wrong");
  sel_false_a: assert property (
    issue_valid_i && issue_op_i == SSSA_OP_SEL_F
    |=> result_o == ($past(select_condition_register_i) == 4'h0 ?
                     $past(src1_i) : $past(opd2_i)))
    else $error("false select wrong");
  one_stage_a: assert property (
    issue_valid_i |=> result_valid_o ##1 (result_valid_o == $past(issue_valid_i)))
    else $error("result not one stage");
  hold_idle_a: assert property (
    !issue_valid_i |=> $stable(result_o))
    else $error("idle result changed");

  shr_cov_c:  cover property (issue_valid_i && issue_op_i == SSSA_OP_SHRU);
  sel_pb_c:   cover property (issue_valid_i && issue_op_i == SSSA_OP_SEL_PB);
  b2b_c:      cover property (issue_valid_i [*3]);
  self_nz_c:  cover property (issue_valid_i && issue_op_i == SSSA_OP_SEL_F &&
                              select_condition_register_i != 4'h0);
endmodule

// ### dv/sssa_issue_model.sv
/* Issue-side model that presents operations to the slice.
   Assumes the bench calls drive once for every cycle it wants to fill. */
`timescale 1ns/100ps
module sssa_issue_model (
  input  wire logic          core_clk_i,
  output logic               vld_o,
  output sssa_pkg::sssa_op_e op_o,
  output logic [31:0]        a_o,
  output logic [31:0]        b_o,
  output logic [3:0]         c_o
);
  import sssa_pkg::*;
  initial begin
    vld_o = 1'b0;
    op_o = SSSA_OP_SHRU;
    a_o = 32'h0000_0000;
    b_o = 32'h0000_0000;
    c_o = 4'h0;
  end
  // Any opcode may follow any other in the next cycle, with no gap.
  task automatic drive(input logic v, input sssa_op_e op, input logic [31:0] a, b,
                       input logic [3:0] c);
    @(negedge core_clk_i);
    vld_o = v;
    op_o = op;
    a_o = a;
    b_o = b;
    c_o = c;
  endtask
endmodule

// ### dv/sssa_alu_bench.sv
/* Self-checking bench for the shift, shuffle and select slice.
   Assumes one result cycle after each issue, as the slice promises. */
`timescale 1ns/100ps
module sssa_alu_bench;
  import sssa_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        vld;
  sssa_op_e    op;
  logic [31:0] a;
  logic [31:0] b;
  logic [3:0]  c;
  logic        res_v;
  logic [31:0] res;
  logic        pend = 1'b0;
  logic [31:0] pexp = 32'h0000_0000;
  int          miscompares = 0;
  int          cmp_count = 0;
  localparam logic [31:0] A = 32'h4433_2211;
  localparam logic [31:0] B = 32'h8877_6655;
  always #12.5 core_clk_i = ~core_clk_i;
  sssa_issue_model i_sssa_issue_model (.core_clk_i(core_clk_i), .vld_o(vld), .op_o(op),
                                       .a_o(a), .b_o(b), .c_o(c));
  sssa_alu i_sssa_alu (.core_clk_i(core_clk_i), .rst_i(rst_i), .issue_valid_i(vld),
                       .issue_op_i(op), .src1_i(a), .opd2_i(b),
                       .select_condition_register_i(c), .result_valid_o(res_v),
                       .result_o(res));
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Drives one cycle and judges the answer to the previous one at the same edge.
  task automatic step(input logic v, input sssa_op_e o, input logic [31:0] x, y,
                      input logic [3:0] k, input logic [31:0] e);
    i_sssa_issue_model.drive(v, o, x, y, k);
    check("valid", {31'h0, res_v}, {31'h0, pend});
    check("result", res, pexp);
    pend = v;
    if (v) begin
      pexp = e;
    end
  endtask
  task automatic t_shift();
    logic [31:0] amt [6];
    logic [31:0] e;
    amt = '{32'h0000_0000, 32'h0000_0001, 32'h0000_001F, 32'h0000_0020,
            32'h0000_00FF, 32'h0000_0104};
    foreach (amt[i]) begin
      e = (amt[i][7:0] > 8'h1F) ? 32'h0000_0000 : 32'h8000_00F1 >> amt[i][7:0];
      step(1'b1, SSSA_OP_SHRU, 32'h8000_00F1, amt[i], 4'h0, e);
    end
    $display("shift test done");
  endtask
  task automatic t_shuffle();
    step(1'b1, SSSA_OP_SHUF_BH, A, B, 4'h0, 32'h8844_7733);
    step(1'b1, SSSA_OP_SHUF_BL, A, B, 4'h0, 32'h6622_5511);
    step(1'b1, SSSA_OP_SHUF_HH, A, B, 4'h0, 32'h8877_4433);
    step(1'b1, SSSA_OP_SHUF_HL, A, B, 4'h0, 32'h6655_2211);
    step(1'b1, SSSA_OP_EVEN, A, B, 4'h0, 32'h7733_5511);
    step(1'b1, SSSA_OP_ODD, A, B, 4'h0, 32'h8844_6622);
    $display("shuffle test done");
  endtask
  task automatic t_select();
    step(1'b1, SSSA_OP_SEL_T, A, B, 4'h0, B);
    step(1'b1, SSSA_OP_SEL_T, A, B, 4'h8, A);
    step(1'b1, SSSA_OP_SEL_PB, A, B, 4'h5, 32'h8833_6611);
    step(1'b1, SSSA_OP_SEL_PB, A, 32'h0000_00EE, 4'hA, 32'h4400_22EE);
    step(1'b1, SSSA_OP_SEL_F, A, 32'hFFFF_FF80, 4'h0, A);
    step(1'b1, SSSA_OP_SEL_F, A, 32'hFFFF_FF80, 4'h2, 32'hFFFF_FF80);
    $display("select test done");
  endtask
  task automatic t_idle();
    step(1'b0, SSSA_OP_SHRU, B, B, 4'hF, 32'h0000_0000);
    step(1'b0, SSSA_OP_SHRU, A, A, 4'h0, 32'h0000_0000);
    step(1'b1, SSSA_OP_SHUF_HL, B, A, 4'h0, 32'h2211_6655);
    step(1'b0, SSSA_OP_SHRU, A, A, 4'h0, 32'h0000_0000);
    $display("idle test done");
  endtask
  // A reset in mid-run clears the result and valid flags before the next issue.
  task automatic t_reset();
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    check("reset valid", {31'h0, res_v}, 32'h0000_0000);
    check("reset result", res, 32'h0000_0000);
    rst_i = 1'b0;
    pend = 1'b0;
    pexp = 32'h0000_0000;
    step(1'b1, SSSA_OP_SHRU, A, 32'h0000_0000, 4'h0, A);
    step(1'b0, SSSA_OP_SHRU, B, B, 4'h0, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    t_shift();
    t_shuffle();
    t_select();
    t_idle();
    t_reset();
    finish_test();
  end
  initial begin
    #(25 * 400);
    miscompares++;
    finish_test();
  end
endmodule
